// >>> pkg/utpo_regs.vh
// Register map, field positions, reset values and codes of the transceiver output test block.
`ifndef UTPO_REGS_VH
`define UTPO_REGS_VH

`define UTPO_ADDR_W 12
`define UTPO_OFS_TEST 12'h000
`define UTPO_OFS_CTRL 12'h004
`define UTPO_OFS_STAT 12'h008

`define UTPO_TEST_ENABLE_BIT 7
`define UTPO_TEST_SUSPEND_BIT 3
`define UTPO_TEST_DRIVE_N_BIT 2
`define UTPO_TEST_SE0_BIT 1
`define UTPO_TEST_DATA_BIT 0
`define UTPO_TEST_WMASK 8'h8F
`define UTPO_TEST_RESET 8'h04

`define UTPO_CTRL_IFRST_BIT 0
`define UTPO_CTRL_CTLRST_BIT 1
`define UTPO_CTRL_FESEL_BIT 2
`define UTPO_CTRL_WMASK 8'h07
`define UTPO_CTRL_RESET 8'h03

`define UTPO_STAT_VBUS_BIT 0
`define UTPO_STAT_ACTIVE_BIT 1
`define UTPO_STAT_EXT_BIT 2

`define UTPO_SYNC_STAGES 2

`endif

// >>> rtl/utpo_sync.v
// Two-flop synchroniser for a level that arrives from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module utpo_sync
(
	input wire clk,
	input wire rst_n,
	input wire async_in,
	output wire sync_out
);

	reg meta;
	reg stable;

	// The first stage is read only by the second stage.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= 1'b0;
			stable <= 1'b0;
		end
		else
		begin
			meta <= async_in;
			stable <= meta;
		end
	end

	assign sync_out = stable;

endmodule
`default_nettype wire

// >>> rtl/utpo_test_override.v
// Transceiver output pin test override with an APB register slave.
`timescale 1ns/10ps
`default_nettype none
`include "utpo_regs.vh"

module utpo_test_override
(
	input wire clk,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`UTPO_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire vbus,
	input wire normal_dp_out,
	input wire normal_dm_out,
	input wire normal_line_drive,
	input wire normal_suspend,
	input wire normal_ext_drive_enable_n,
	input wire normal_ext_se_zero,
	input wire normal_ext_line_data,
	input wire normal_ext_suspend,
	output reg usb_dp_out,
	output reg usb_dp_oe,
	output reg usb_dm_out,
	output reg usb_dm_oe,
	output reg suspend_indication_out,
	output reg external_drive_enable_pin,
	output reg external_se_zero_pin,
	output reg external_line_data_pin,
	output reg external_suspend_pin,
	output reg interface_reset_bit,
	output reg controller_reset_bit,
	output reg front_end_select
);

	////////////////////////////////////////////////////////////////////////////////////////////
	// Register storage and bus decode.

	reg [7:0] transceiver_output_test;
	wire vbus_sync;
	wire access_done;
	wire write_done;
	wire test_active;
	wire sel_test;
	wire sel_ctrl;
	wire sel_stat;
	wire mapped;
	wire answer_start;
	wire [7:0] ctrl_word;
	wire [7:0] stat_word;

	// Reset word of the control copies; each copy takes its own bit of it.
	localparam [7:0] CTRL_RESET = `UTPO_CTRL_RESET;

	// Only the three word addresses decode; anything else is answered with an error.
	function [2:0] utpo_decode;
		input [`UTPO_ADDR_W-1:0] addr;
		begin
			utpo_decode = 3'h0;
			case (addr)
				`UTPO_OFS_TEST: utpo_decode = 3'h1;
				`UTPO_OFS_CTRL: utpo_decode = 3'h2;
				`UTPO_OFS_STAT: utpo_decode = 3'h4;
				default: utpo_decode = 3'h0;
			endcase
		end
	endfunction

	assign sel_test = utpo_decode(paddr) == 3'h1;
	assign sel_ctrl = utpo_decode(paddr) == 3'h2;
	assign sel_stat = utpo_decode(paddr) == 3'h4;
	assign mapped = utpo_decode(paddr) != 3'h0;
	assign access_done = psel & penable & pready;
	assign write_done = access_done & pwrite & mapped;
	// The answer is prepared in the first access cycle and stands for exactly one cycle.
	assign answer_start = psel & penable & ~pready;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Bus power synchronisation and test gating.

	// Bus power comes from a pin, so it is re-timed before any decision uses it.
	utpo_sync vbus_sync_inst
	(
		.clk(clk),
		.rst_n(rst_n),
		.async_in(vbus),
		.sync_out(vbus_sync)
	);

	// Override only counts while both reset bits are clear.
	assign test_active = transceiver_output_test[`UTPO_TEST_ENABLE_BIT] &
		~interface_reset_bit & ~controller_reset_bit;

	// Unused control and status bits read as zero.
	assign ctrl_word = {5'h00, front_end_select, controller_reset_bit, interface_reset_bit};
	assign stat_word = {5'h00, front_end_select, test_active, vbus_sync};

	////////////////////////////////////////////////////////////////////////////////////////////
	// Bus answer and register writes.

	// One wait state keeps pready, prdata and pslverr straight from flip-flops.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			pready <= answer_start;
			pslverr <= answer_start & ~mapped;
			// Read data is zero outside the answer cycle, so a stale word never lingers.
			prdata <= 32'h00000000;
			if (answer_start & ~pwrite)
			begin
				if (sel_test)
				begin
					prdata <= {24'h000000, transceiver_output_test};
				end
				else if (sel_ctrl)
				begin
					prdata <= {24'h000000, ctrl_word};
				end
				else if (sel_stat)
				begin
					prdata <= {24'h000000, stat_word};
				end
			end
		end
	end

	// Writes land at the edge where the master sees pready high.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			transceiver_output_test <= `UTPO_TEST_RESET;
			interface_reset_bit <= CTRL_RESET[`UTPO_CTRL_IFRST_BIT];
			controller_reset_bit <= CTRL_RESET[`UTPO_CTRL_CTLRST_BIT];
			front_end_select <= CTRL_RESET[`UTPO_CTRL_FESEL_BIT];
		end
		else if (write_done)
		begin
			// Status is read-only: a write to it completes without error and is dropped.
			if (sel_test)
			begin
				// Reserved bits are masked on the way in, so they read back as zero.
				transceiver_output_test <= pwdata[7:0] & `UTPO_TEST_WMASK;
			end
			else if (sel_ctrl)
			begin
				// Clearing both reset bits is what arms the test enable.
				interface_reset_bit <= pwdata[`UTPO_CTRL_IFRST_BIT];
				controller_reset_bit <= pwdata[`UTPO_CTRL_CTLRST_BIT];
				front_end_select <= pwdata[`UTPO_CTRL_FESEL_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Output selection.

	reg next_dp_out;
	reg next_dp_oe;
	reg next_dm_out;
	reg next_dm_oe;
	reg next_suspend;
	reg next_ext_drive_enable;
	reg next_ext_se_zero;
	reg next_ext_line_data;
	reg next_ext_suspend;
	wire set_suspend;
	wire set_drive_n;
	wire set_se0;
	wire set_data;

	// Setting bits of the test register, named by what they drive.
	assign set_suspend = transceiver_output_test[`UTPO_TEST_SUSPEND_BIT];
	assign set_drive_n = transceiver_output_test[`UTPO_TEST_DRIVE_N_BIT];
	assign set_se0 = transceiver_output_test[`UTPO_TEST_SE0_BIT];
	assign set_data = transceiver_output_test[`UTPO_TEST_DATA_BIT];

	// Normal values are the defaults, so test mode names only what it overrides.
	always @*
	begin
		next_dp_out = normal_dp_out;
		next_dm_out = normal_dm_out;
		next_dp_oe = normal_line_drive;
		next_dm_oe = normal_line_drive;
		next_suspend = normal_suspend;
		next_ext_drive_enable = normal_ext_drive_enable_n;
		next_ext_se_zero = normal_ext_se_zero;
		next_ext_line_data = normal_ext_line_data;
		next_ext_suspend = normal_ext_suspend;
		if (test_active)
		begin
			next_suspend = set_suspend;
			// Internal lines float unless internal mode, bus power and drive enabled.
			next_dp_oe = 1'b0;
			next_dm_oe = 1'b0;
			next_dp_out = 1'b0;
			next_dm_out = 1'b0;
			if (!front_end_select)
			begin
				if (vbus_sync && !set_drive_n)
				begin
					next_dp_oe = 1'b1;
					next_dm_oe = 1'b1;
					if (set_se0)
					begin
						next_dp_out = 1'b0;
						next_dm_out = 1'b0;
					end
					else
					begin
						next_dp_out = set_data;
						next_dm_out = ~set_data;
					end
				end
			end
			else
			begin
				next_ext_se_zero = set_se0;
				next_ext_line_data = set_data;
				if (vbus_sync)
				begin
					next_ext_suspend = set_suspend;
					next_ext_drive_enable = set_drive_n;
				end
				else
				begin
					// Without bus power the external transceiver is parked suspended and undriven.
					next_ext_suspend = 1'b1;
					next_ext_drive_enable = 1'b1;
				end
			end
		end
	end

	// Every pin is re-timed so a register change reaches all pins on one edge.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			usb_dp_out <= 1'b0;
			usb_dp_oe <= 1'b0;
			usb_dm_out <= 1'b0;
			usb_dm_oe <= 1'b0;
			suspend_indication_out <= 1'b0;
		end
		else
		begin
			usb_dp_out <= next_dp_out;
			usb_dp_oe <= next_dp_oe;
			usb_dm_out <= next_dm_out;
			usb_dm_oe <= next_dm_oe;
			suspend_indication_out <= next_suspend;
		end
	end

	// The external drive enable is active low, so reset parks it at its inactive level.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			external_drive_enable_pin <= 1'b1;
			external_se_zero_pin <= 1'b0;
			external_line_data_pin <= 1'b0;
			external_suspend_pin <= 1'b0;
		end
		else
		begin
			external_drive_enable_pin <= next_ext_drive_enable;
			external_se_zero_pin <= next_ext_se_zero;
			external_line_data_pin <= next_ext_line_data;
			external_suspend_pin <= next_ext_suspend;
		end
	end

endmodule
`default_nettype wire

// >>> verification/utpo_xcvr.sv
// Behavioural model of the transceiver data lines at the far side of the block.
`timescale 1ns/10ps
`default_nettype none
module utpo_xcvr
(
	input wire logic clk,
	input wire logic usb_dp_out,
	input wire logic usb_dp_oe,
	input wire logic usb_dm_out,
	input wire logic usb_dm_oe,
	output wire logic dp_line,
	output wire logic dm_line
);
	logic dp_last = 1'b0;
	logic dm_last = 1'b0;
	// A released line shows the inverse of its last driven level, so a floating
	// line never passes as the value the block drove before.
	assign dp_line = usb_dp_oe ? usb_dp_out : ~dp_last;
	assign dm_line = usb_dm_oe ? usb_dm_out : ~dm_last;
	always @(posedge clk)
	begin
		if (usb_dp_oe)
			dp_last <= usb_dp_out;
		if (usb_dm_oe)
			dm_last <= usb_dm_out;
	end
endmodule
`default_nettype wire

// >>> verification/utpo_test_override_sva.sv
// Checker of the transceiver output test block, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
`include "utpo_regs.vh"
module utpo_sva
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic vbus,
	input wire logic [`UTPO_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic normal_line_drive,
	input wire logic normal_ext_line_data,
	input wire logic usb_dp_oe,
	input wire logic usb_dm_oe,
	input wire logic suspend_indication_out,
	input wire logic external_drive_enable_pin,
	input wire logic external_se_zero_pin,
	input wire logic external_line_data_pin,
	input wire logic external_suspend_pin
);
	logic [7:0] tst;
	logic [2:0] ctl;
	wire act = tst[7] && !ctl[0] && !ctl[1];
	wire done = psel && penable && pready && pwrite;
	// Shadows are taken from the bus so that a lagging status copy cannot mask a fault.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tst <= 8'h04;
			ctl <= 3'h3;
		end
		else if (done && paddr == 12'h000)
			tst <= pwdata[7:0];
		else if (done && paddr == 12'h004)
			ctl <= pwdata[2:0];
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	ready_wait_a: assert property (psel && !penable |=> !pready ##1 pready ##1 !pready)
		else $error("ready not one wait");
	err_map_a: assert property (pslverr == (pready && paddr != 12'h000 && paddr != 12'h004 &&
		paddr != 12'h008))
		else $error("slave error wrong");
	rsv_zero_a: assert property (pready && !pwrite && paddr == 12'h000 |->
		prdata[31:8] == 0 && prdata[6:4] == 0) else $error("reserved bits set");
	normal_follow_a: assert property (ctl[0] |=> usb_dp_oe == $past(normal_line_drive) &&
		external_line_data_pin == $past(normal_ext_line_data)) else $error("normal lost");
	susp_set_a: assert property (act |=> suspend_indication_out == $past(tst[3]))
		else $error("suspend wrong");
	line_float_a: assert property (act && (ctl[2] || tst[2]) |=> !usb_dp_oe && !usb_dm_oe)
		else $error("lines driven");
	ext_bits_a: assert property (act && ctl[2] |=> external_se_zero_pin == $past(tst[1]) &&
		external_line_data_pin == $past(tst[0])) else $error("pin bits wrong");
	int_ext_keep_a: assert property (!ctl[2] |=>
		external_line_data_pin == $past(normal_ext_line_data)) else $error("pin overridden");
	nobus_force_a: assert property ((!vbus [*4]) ##0 (act && ctl[2]) |=>
		external_suspend_pin && external_drive_enable_pin) else $error("pins not forced");
	cover property (act && ctl[2] && !vbus);
	cover property (act && !ctl[2] && usb_dp_oe);
	cover property (pslverr);
endmodule
bind utpo_test_override utpo_sva chk (.clk, .rst_n, .psel, .penable, .pwrite, .pready,
	.pslverr, .vbus, .paddr, .pwdata, .prdata, .normal_line_drive, .normal_ext_line_data,
	.usb_dp_oe, .usb_dm_oe, .suspend_indication_out, .external_drive_enable_pin,
	.external_se_zero_pin, .external_line_data_pin, .external_suspend_pin);
`default_nettype wire

// >>> verification/tb_usb_transceiver_pin_test_override.sv
// Self-checking bench of the transceiver output test block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_usb_transceiver_pin_test_override;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, vbus = 0, er;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [7:0] nrm = 8'hA5;
	logic pready, pslverr, usb_dp_out, usb_dp_oe, usb_dm_out, usb_dm_oe, dp_line, dm_line;
	logic suspend_indication_out, external_drive_enable_pin, external_se_zero_pin;
	logic external_line_data_pin, external_suspend_pin;
	logic interface_reset_bit, controller_reset_bit, front_end_select;
	int error_cnt = 0, tests_run = 0, cyc = 0;
	logic [7:0] tv [5] = '{8'h80, 8'h81, 8'h82, 8'h84, 8'h88};
	logic [4:0] ev [5] = '{5'h1A, 5'h1C, 5'h18, 5'h00, 5'h1B};
	wire [3:0] ext = {external_suspend_pin, external_drive_enable_pin,
		external_se_zero_pin, external_line_data_pin};
	wire [4:0] intl = {usb_dp_oe, usb_dm_oe, dp_line & usb_dp_oe, dm_line & usb_dm_oe,
		suspend_indication_out};
	utpo_test_override dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .vbus, .normal_dp_out(nrm[7]), .normal_dm_out(nrm[6]),
		.normal_line_drive(nrm[5]), .normal_suspend(nrm[4]),
		.normal_ext_drive_enable_n(nrm[3]), .normal_ext_se_zero(nrm[2]),
		.normal_ext_line_data(nrm[1]), .normal_ext_suspend(nrm[0]), .usb_dp_out,
		.usb_dp_oe, .usb_dm_out, .usb_dm_oe, .suspend_indication_out,
		.external_drive_enable_pin, .external_se_zero_pin, .external_line_data_pin,
		.external_suspend_pin, .interface_reset_bit, .controller_reset_bit,
		.front_end_select);
	utpo_xcvr far (.clk, .usb_dp_out, .usb_dp_oe, .usb_dm_out, .usb_dm_oe, .dp_line, .dm_line);
	always #25 clk = ~clk;
	////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 3000)
		begin
			error_cnt++;
			complete_run();
		end
	end
	// One idle cycle follows each transfer, so no strobe is driven twice in a step.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d);
		@(posedge clk);
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		apb(0, 12'h000, 0);
		`CHK(rd, 32'h00000004)
		apb(0, 12'h004, 0);
		`CHK(rd, 32'h00000003)
		`CHK({interface_reset_bit, controller_reset_bit, front_end_select}, 3'h6)
		apb(0, 12'h00C, 0);
		`CHK({er, rd}, 33'h100000000)
		wr(12'h000, 32'hFFFFFFFF);
		apb(0, 12'h000, 0);
		`CHK(rd, 32'h0000008F)
		`CHK({usb_dp_oe, usb_dp_out, external_suspend_pin}, 3'h7)
		vbus <= 1;
		wr(12'h004, 0);
		`CHK({interface_reset_bit, controller_reset_bit, front_end_select}, 3'h0)
		foreach (tv[i])
		begin
			wr(12'h000, 32'(tv[i]));
			`CHK(intl, ev[i])
		end
		wr(12'h004, 32'h00000004);
		`CHK({interface_reset_bit, controller_reset_bit, front_end_select}, 3'h1)
		wr(12'h000, 32'h0000008B);
		`CHK({ext, usb_dp_oe}, 5'h16)
		vbus <= 0;
		wr(12'h000, 32'h00000080);
		`CHK({ext, suspend_indication_out, usb_dm_oe}, 6'h30)
		wr(12'h008, 0);
		apb(0, 12'h008, 0);
		`CHK({er, rd}, 33'h000000006)
		nrm <= 8'h5A;
		wr(12'h004, 32'h00000005);
		`CHK({interface_reset_bit, controller_reset_bit, front_end_select}, 3'h5)
		`CHK({ext, usb_dp_oe}, 5'h0A)
		complete_run();
	end
endmodule
`default_nettype wire
